//--- inc/emb_pkg.sv
// Shared types and constants of the external memory bus interface
package emb_pkg;

   // Kind of external bus cycle in progress
   typedef enum logic [1:0] {
      EMB_NONE,
      EMB_FETCH,
      EMB_READ,
      EMB_WRITE
   } emb_op_t;

   // Phase numbers, one phase per oscillator period
   localparam logic [2:0] EMB_ADDR_PHASE    = 3'h0;
   localparam logic [2:0] EMB_FETCH_STB_1ST = 3'h1;
   localparam logic [2:0] EMB_FETCH_LAST    = 3'h2;
   localparam logic [2:0] EMB_DATA_STB_1ST  = 3'h2;
   localparam logic [2:0] EMB_DATA_STB_LAST = 3'h4;
   localparam logic [2:0] EMB_DATA_LAST     = 3'h5;
   localparam logic [2:0] EMB_READ_CAPTURE  = 3'h4;

   // Highest program address served from on-chip memory
   localparam logic [15:0] EMB_INT_ROM_TOP = 16'h7fff;

   // Port latch values
   localparam logic [7:0] EMB_P0_BUS_LOAD = 8'hff;
   localparam logic [7:0] EMB_LATCH_RESET = 8'hff;
   localparam logic [7:0] EMB_ALL_DRIVE   = 8'hff;
   localparam logic [7:0] EMB_NO_DRIVE    = 8'h00;

   // Request from the core; addr holds the program counter for fetches
   typedef struct packed {
      emb_op_t     op;
      logic        ptr_mode;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } emb_req_t;

   // Answer to the core
   typedef struct packed {
      logic       internal;
      logic [7:0] data;
   } emb_rsp_t;

endpackage

//--- test/emb_ext_bus_test.sv
// Self-checking testbench of the external bus controller
`timescale 1ns/1ps
`default_nettype none
module emb_ext_bus_test;
   logic clk, rst, req_valid, ready, rsp_valid, p0w, p2w, sel_n, slow;
   logic ale, pss_n, rd_n, wr_n;
   emb_pkg::emb_req_t req;
   emb_pkg::emb_rsp_t rsp;
   logic [7:0] p0wd, p0l, p2wd, p2l, p0_pin, p0_out, p0_oe, p2_out, pu;
   logic [7:0] bus, wd;
   logic [15:0] wa;
   int err_count, checks, ncyc, n_ps, n_rd, n_wr, n_ale, n_p2, n_p0;

   // Wire level: driven bits from the block, the rest from memory
   assign p0_pin = (p0_oe & p0_out) | (~p0_oe & bus);

   emb_ext_bus dut (.clock_in(clk), .rst_in(rst), .req_valid_in(req_valid),
      .req_in(req), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
      .rsp_out(rsp), .p0_latch_wr_in(p0w), .p0_latch_wdata_in(p0wd),
      .p0_latch_out(p0l), .p2_latch_wr_in(p2w), .p2_latch_wdata_in(p2wd),
      .p2_latch_out(p2l), .external_access_select_n_in(sel_n),
      .p0_in(p0_pin), .p0_out(p0_out), .p0_oe_out(p0_oe), .p2_out(p2_out),
      .p2_strong_pullup_out(pu), .ale_out(ale),
      .program_store_strobe_n_out(pss_n), .rd_n_out(rd_n), .wr_n_out(wr_n));

   emb_mem_model mem (.clock_in(clk), .slow_in(slow), .p0_pin_in(p0_pin),
      .p2_in(p2_out), .ale_in(ale), .pss_n_in(pss_n), .rd_n_in(rd_n),
      .wr_n_in(wr_n), .bus_out(bus), .wr_addr_out(wa), .wr_data_out(wd));

   // Expected memory answer, worked out independently of the model
   function automatic logic [7:0] mix(input logic [7:0] h, input logic [7:0] l);
      return h ^ {l[3:0], l[7:4]} ^ 8'h5a;
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One request, then a per-cycle tally of strobes and bus contents
   task automatic run(input emb_pkg::emb_op_t op, input logic ptr,
      input logic [15:0] a, input logic [7:0] d, input logic [7:0] hexp,
      input logic [7:0] puexp);
      int i;
      {n_ps, n_rd, n_wr, n_ale, n_p2, n_p0} = '0;
      for (i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk);
      if (ready !== 1'b1) begin
         err_count++;
         end_sim();
      end
      req_valid = 1'b1;
      req = '{op, ptr, a, d};
      @(negedge clk);
      req_valid = 1'b0;
      for (ncyc = 1; ncyc < 20; ncyc++) begin
         n_ps += (pss_n === 1'b0);
         n_rd += (rd_n === 1'b0);
         n_wr += (wr_n === 1'b0);
         n_ale += (ale === 1'b1);
         if (ale === 1'b1 || pss_n === 1'b0 || rd_n === 1'b0 || wr_n === 1'b0)
            n_p2 += (p2_out !== hexp) || (pu !== puexp);
         if (ale === 1'b1)
            n_p0 += (p0_out !== a[7:0]) || (p0_oe !== 8'hff);
         if (wr_n === 1'b0)
            n_p0 += (p0_out !== d) || (p0_oe !== 8'hff);
         if (rsp_valid === 1'b1) break;
         @(negedge clk);
      end
      if (ncyc == 20) begin
         err_count++;
         end_sim();
      end
   endtask

   task automatic latch_wr(input logic sel2, input logic [7:0] v);
      p0w = !sel2;
      p2w = sel2;
      p0wd = v;
      p2wd = v;
      @(negedge clk);
      {p0w, p2w} = 2'b00;
      @(negedge clk);
   endtask

   task automatic t_reset();
      chk("ready", ready, 0);
      chk("strobes", {ale, pss_n, rd_n, wr_n}, 4'h7);
      chk("p0 drive", p0_oe, 8'h00);
      chk("latches", {p0l, p2l}, 16'hffff);
      $display("test reset done");
   endtask

   // Select pin low, high page address, and internal space
   task automatic t_fetch();
      logic [15:0] at [3];
      logic        sl [3];
      logic        ext;
      int          k;
      at = '{16'h1234, 16'h8000, 16'h7fff};
      sl = '{1'b0, 1'b1, 1'b1};
      for (k = 0; k < 3; k++) begin
         sel_n = sl[k];
         repeat (3) @(negedge clk);
         ext = !sl[k] || at[k] > 16'h7fff;
         run(emb_pkg::EMB_FETCH, 1'b0, at[k], 8'h00, at[k][15:8], at[k][15:8]);
         chk("fetch cycles", ncyc, ext ? 5 : 1);
         chk("prog strobes", n_ps, ext ? 2 : 0);
         chk("rd wr in fetch", n_rd + n_wr, 0);
         chk("ale in fetch", n_ale, ext);
         chk("fetch p2", n_p2, 0);
         chk("fetch p0", n_p0, 0);
         chk("internal", rsp.internal, !ext);
         chk("fetch data", rsp.data,
             ext ? mix(at[k][15:8], at[k][7:0]) : 0);
      end
      sel_n = 1'b1;
      $display("test fetch done");
   endtask

   // Pointer or register indirect read, prompt or slow memory
   task automatic t_read(input logic ptr, input logic sl);
      logic [7:0] h;
      h = ptr ? 8'ha5 : 8'h3c;
      slow = sl;
      latch_wr(1'b1, 8'h3c);
      run(emb_pkg::EMB_READ, ptr, 16'ha5c3, 8'h00, h, ptr ? 8'ha5 : 8'h00);
      slow = 1'b0;
      chk("read cycles", ncyc, 6);
      chk("rd pulses", n_rd, 3);
      chk("prog strobe in read", n_ps, 0);
      chk("read p2", n_p2, 0);
      chk("read p0", n_p0, 0);
      chk("read data", rsp.data, mix(h, 8'hc3));
      chk("p2 latch", p2l, 8'h3c);
      $display("test read done");
   endtask

   // Write over a software value in the port 0 latch
   task automatic t_write();
      latch_wr(1'b0, 8'h55);
      latch_wr(1'b1, 8'h81);
      chk("p0 latch sw", p0l, 8'h55);
      run(emb_pkg::EMB_WRITE, 1'b1, 16'h0102, 8'h9e, 8'h01, 8'h01);
      chk("write cycles", ncyc, 7);
      chk("wr pulses", n_wr, 3);
      chk("rd in write", n_rd + n_ps, 0);
      chk("write bus", {n_p0[7:0], n_p2[7:0]}, 0);
      chk("write addr", wa, 16'h0102);
      chk("write data", wd, 8'h9e);
      chk("p0 latch", p0l, 8'hff);
      chk("p2 latch kept", p2l, 8'h81);
      $display("test write done");
   endtask

   // Free-running core clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Main sequence, inputs change on the falling edge
   initial begin
      {err_count, checks} = '0;
      {rst, sel_n} = 2'b11;
      {req_valid, p0w, p2w, slow} = 4'h0;
      req = '0;
      {p0wd, p2wd} = 16'h0000;
      repeat (10) @(negedge clk);
      t_reset();
      rst = 1'b0;
      t_fetch();
      t_read(1'b1, 1'b0);
      t_read(1'b0, 1'b1);
      t_write();
      end_sim();
   end
endmodule
`default_nettype wire

//--- test/emb_mem_model.sv
// Behavioural external memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
   input  wire logic        clock_in,
   input  wire logic        slow_in,
   input  wire logic [7:0]  p0_pin_in,
   input  wire logic [7:0]  p2_in,
   input  wire logic        ale_in,
   input  wire logic        pss_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        wr_n_in,
   output logic      [7:0]  bus_out,
   output logic      [15:0] wr_addr_out,
   output logic      [7:0]  wr_data_out
);
   logic [7:0] lo_q   = 8'h00;
   logic [7:0] last_q = 8'h00;
   logic       seen_q = 1'b0;
   logic       strobe;
   logic       drive;
   logic [7:0] rdata;
   // Read data is a fixed mix of port 2 and the latched low address
   assign rdata  = p2_in ^ {lo_q[3:0], lo_q[7:4]} ^ 8'h5a;
   assign strobe = !pss_n_in || !rd_n_in;
   // Slow reads start half way into the first strobe period
   assign drive  = strobe && (!slow_in || seen_q || !pss_n_in);
   // Late start still settles before the end of that first period
   always @(negedge clock_in) begin
      seen_q <= !rd_n_in;
   end
   // A released bus shows the inverse, so stale data never passes
   assign bus_out = drive ? rdata : ~last_q;
   // Address capture on the latch strobe, write capture on the strobe
   always @(posedge clock_in) begin
      if (drive) last_q <= rdata;
      if (ale_in) lo_q <= p0_pin_in;
      if (!wr_n_in) begin
         wr_addr_out <= {p2_in, lo_q};
         wr_data_out <= p0_pin_in;
      end
   end
endmodule
`default_nettype wire

//--- verilog/emb_ext_bus.sv
// Multiplexed external program and data memory bus controller
`timescale 1ns/1ps
`default_nettype none
// Contract
// - External program fetches strobe only the program store strobe.
// - Data transfers use the read and write strobes of port 3 bits 7, 6.
// - External fetches put a 16-bit address on port 0 low and port 2 high.
// - Pointer-indirect transfers address 16 bits, register-indirect 8 bits.
// - Port 0 multiplexes low address and data from bus logic, not its latch.
// - Port 0 drives both levels while acting as address/data bus.
// - Every external access loads all ones into the port 0 latch.
// - Port 2 holds the high address byte stable for whole 16-bit cycles.
// - Port 2 latch stays unchanged while port 2 carries an address.
// - Register-indirect transfers keep the port 2 latch on port 2 pins.
// - Port 2 address ones use strong pull-ups for the whole cycle.
// - Data cycle lasts six oscillator periods, fetch cycle three.
// - Fetch externally when select input low or program counter above 7FFF.
// - Program strobe pulses only for external fetches, never internal ones.
// - Write data precedes and outlasts write strobe; memory drives reads.
module emb_ext_bus (
   input  wire logic              clock_in,
   input  wire logic              rst_in,
   input  wire logic              req_valid_in,
   input  wire emb_pkg::emb_req_t req_in,
   output logic                   req_ready_out,
   output logic                   rsp_valid_out,
   output emb_pkg::emb_rsp_t      rsp_out,
   input  wire logic              p0_latch_wr_in,
   input  wire logic [7:0]        p0_latch_wdata_in,
   output logic      [7:0]        p0_latch_out,
   input  wire logic              p2_latch_wr_in,
   input  wire logic [7:0]        p2_latch_wdata_in,
   output logic      [7:0]        p2_latch_out,
   input  wire logic              external_access_select_n_in,
   input  wire logic [7:0]        p0_in,
   output logic      [7:0]        p0_out,
   output logic      [7:0]        p0_oe_out,
   output logic      [7:0]        p2_out,
   output logic      [7:0]        p2_strong_pullup_out,
   output logic                   ale_out,
   output logic                   program_store_strobe_n_out,
   output logic                   rd_n_out,
   output logic                   wr_n_out
);

   emb_pkg::emb_op_t  op_ff,      nxt_op;
   logic [2:0]        phase_ff,   nxt_phase;
   emb_pkg::emb_req_t req_ff,     nxt_req;
   logic              ready_ff,   nxt_ready;
   logic              rsp_vld_ff, nxt_rsp_vld;
   emb_pkg::emb_rsp_t rsp_ff,     nxt_rsp;
   logic [7:0]        p0_ff,      nxt_p0;
   logic [7:0]        p0_oe_ff,   nxt_p0_oe;
   logic [7:0]        p2_ff,      nxt_p2;
   logic [7:0]        pull_ff,    nxt_pull;
   logic              ale_ff,     nxt_ale;
   logic              pss_n_ff,   nxt_pss_n;
   logic              rd_n_ff,    nxt_rd_n;
   logic              wr_n_ff,    nxt_wr_n;
   logic              late_ff,    nxt_late;
   logic              sel_n_sync;
   logic [7:0]        p0_sync;
   logic [7:0]        p0_latch;
   logic [7:0]        p2_latch;
   logic              take_ext;
   logic              fetch_ext;
   logic              capture;
   logic              wide_addr;
   logic [2:0]        last_phase;
   logic              wide_q;

   // Select pin resets to inactive so no fetch goes out before sampling
   emb_sync #(.W(1), .RESET_VAL(1'b1)) u_sel_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .d_in     (external_access_select_n_in),
      .q_out    (sel_n_sync)
   );

   // Read data crosses in from the pins
   emb_sync #(.W(8), .RESET_VAL(8'h00)) u_p0_sync (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .d_in     (p0_in),
      .q_out    (p0_sync)
   );

   // Port 0 latch overwritten with ones on each external access
   emb_port_latch #(
      .RESET_VAL (emb_pkg::EMB_LATCH_RESET),
      .LOAD_VAL  (emb_pkg::EMB_P0_BUS_LOAD)
   ) u_p0_latch (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .wr_in    (p0_latch_wr_in),
      .wdata_in (p0_latch_wdata_in),
      .load_in  (take_ext),
      .q_out    (p0_latch)
   );

   // Port 2 latch is never touched by bus cycles
   emb_port_latch #(
      .RESET_VAL (emb_pkg::EMB_LATCH_RESET),
      .LOAD_VAL  (emb_pkg::EMB_LATCH_RESET)
   ) u_p2_latch (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .wr_in    (p2_latch_wr_in),
      .wdata_in (p2_latch_wdata_in),
      .load_in  (1'b0),
      .q_out    (p2_latch)
   );

   // External fetch decision on the synchronised select pin
   assign fetch_ext = !sel_n_sync
                    || (req_in.addr > emb_pkg::EMB_INT_ROM_TOP);

   // Sequencer: phase count per cycle type, answer on capture
   always_comb begin
      nxt_op      = op_ff;
      nxt_phase   = phase_ff;
      nxt_req     = req_ff;
      nxt_rsp_vld = 1'b0;
      nxt_rsp     = rsp_ff;
      take_ext    = 1'b0;
      capture     = 1'b0;
      nxt_late    = 1'b0;
      last_phase  = (op_ff == emb_pkg::EMB_FETCH) ?
                    emb_pkg::EMB_FETCH_LAST : emb_pkg::EMB_DATA_LAST;
      if (op_ff == emb_pkg::EMB_NONE) begin
         if (late_ff) begin
            nxt_rsp_vld = 1'b1;
            nxt_rsp     = '{internal: 1'b0, data: p0_sync};
         end else if (req_valid_in && ready_ff) begin
            if (req_in.op == emb_pkg::EMB_FETCH && !fetch_ext) begin
               // Internal fetch: answered at once, no strobe
               nxt_rsp_vld = 1'b1;
               nxt_rsp     = '{internal: 1'b1, data: 8'h00};
            end else if (req_in.op != emb_pkg::EMB_NONE) begin
               nxt_op    = req_in.op;
               nxt_phase = emb_pkg::EMB_ADDR_PHASE;
               nxt_req   = req_in;
               take_ext  = 1'b1;
            end
         end
      end else begin
         // Fetch byte clears the synchroniser one period after the fetch
         nxt_late = (op_ff == emb_pkg::EMB_FETCH)
                 && (phase_ff == emb_pkg::EMB_FETCH_LAST);
         capture = (op_ff == emb_pkg::EMB_READ
                    && phase_ff == emb_pkg::EMB_READ_CAPTURE)
                || (op_ff == emb_pkg::EMB_WRITE
                    && phase_ff == emb_pkg::EMB_DATA_LAST);
         if (capture) begin
            nxt_rsp_vld  = 1'b1;
            nxt_rsp.internal = 1'b0;
            nxt_rsp.data = (op_ff == emb_pkg::EMB_WRITE) ?
                           8'h00 : p0_sync;
         end
         if (phase_ff == last_phase) begin
            nxt_op    = emb_pkg::EMB_NONE;
            nxt_phase = emb_pkg::EMB_ADDR_PHASE;
         end else begin
            nxt_phase = phase_ff + 3'h1;
         end
      end
      nxt_ready = (nxt_op == emb_pkg::EMB_NONE) && !nxt_late;
   end

   // Pin values from the next state, so pins line up with the phase
   always_comb begin
      wide_addr  = (nxt_op == emb_pkg::EMB_FETCH)
                || (nxt_op != emb_pkg::EMB_NONE && nxt_req.ptr_mode);
      nxt_ale    = (nxt_op != emb_pkg::EMB_NONE)
                && (nxt_phase == emb_pkg::EMB_ADDR_PHASE);
      nxt_pss_n  = !(nxt_op == emb_pkg::EMB_FETCH
                     && nxt_phase >= emb_pkg::EMB_FETCH_STB_1ST);
      nxt_rd_n   = !(nxt_op == emb_pkg::EMB_READ
                     && nxt_phase >= emb_pkg::EMB_DATA_STB_1ST
                     && nxt_phase <= emb_pkg::EMB_DATA_STB_LAST);
      nxt_wr_n   = !(nxt_op == emb_pkg::EMB_WRITE
                     && nxt_phase >= emb_pkg::EMB_DATA_STB_1ST
                     && nxt_phase <= emb_pkg::EMB_DATA_STB_LAST);
      // Idle port 0 is open drain: only zeros are driven
      nxt_p0     = p0_latch;
      nxt_p0_oe  = ~p0_latch;
      case (nxt_op)
         emb_pkg::EMB_FETCH: begin
            nxt_p0    = nxt_req.addr[7:0];
            nxt_p0_oe = (nxt_phase == emb_pkg::EMB_ADDR_PHASE) ?
                        emb_pkg::EMB_ALL_DRIVE : emb_pkg::EMB_NO_DRIVE;
         end
         emb_pkg::EMB_READ: begin
            // Address kept one period past the latch strobe; memory
            // owns port 0 from the read strobe on
            nxt_p0    = nxt_req.addr[7:0];
            nxt_p0_oe = (nxt_phase < emb_pkg::EMB_DATA_STB_1ST) ?
                        emb_pkg::EMB_ALL_DRIVE : emb_pkg::EMB_NO_DRIVE;
         end
         emb_pkg::EMB_WRITE: begin
            // Data one period before the strobe and one after
            nxt_p0    = (nxt_phase == emb_pkg::EMB_ADDR_PHASE) ?
                        nxt_req.addr[7:0] : nxt_req.wdata;
            nxt_p0_oe = emb_pkg::EMB_ALL_DRIVE;
         end
         default: begin
            nxt_p0    = p0_latch;
            nxt_p0_oe = ~p0_latch;
         end
      endcase
      // Port 2: high address with full-cycle strong pull-ups, else latch
      nxt_p2   = wide_addr ? nxt_req.addr[15:8] : p2_latch;
      nxt_pull = wide_addr ? nxt_req.addr[15:8]
                           : emb_pkg::EMB_NO_DRIVE;
   end

   // All state and pins registered together
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         op_ff      <= emb_pkg::EMB_NONE;
         phase_ff   <= emb_pkg::EMB_ADDR_PHASE;
         req_ff     <= '0;
         ready_ff   <= 1'b0;
         rsp_vld_ff <= 1'b0;
         rsp_ff     <= '0;
         p0_ff      <= emb_pkg::EMB_LATCH_RESET;
         p0_oe_ff   <= emb_pkg::EMB_NO_DRIVE;
         p2_ff      <= emb_pkg::EMB_LATCH_RESET;
         pull_ff    <= emb_pkg::EMB_NO_DRIVE;
         ale_ff     <= 1'b0;
         pss_n_ff   <= 1'b1;
         late_ff    <= 1'b0;
         rd_n_ff    <= 1'b1;
         wr_n_ff    <= 1'b1;
      end else begin
         op_ff      <= nxt_op;
         phase_ff   <= nxt_phase;
         req_ff     <= nxt_req;
         ready_ff   <= nxt_ready;
         rsp_vld_ff <= nxt_rsp_vld;
         rsp_ff     <= nxt_rsp;
         p0_ff      <= nxt_p0;
         p0_oe_ff   <= nxt_p0_oe;
         p2_ff      <= nxt_p2;
         pull_ff    <= nxt_pull;
         ale_ff     <= nxt_ale;
         pss_n_ff   <= nxt_pss_n;
         late_ff    <= nxt_late;
         rd_n_ff    <= nxt_rd_n;
         wr_n_ff    <= nxt_wr_n;
      end
   end

   // Outputs straight from flops
   assign req_ready_out              = ready_ff;
   assign rsp_valid_out              = rsp_vld_ff;
   assign rsp_out                    = rsp_ff;
   assign p0_latch_out               = p0_latch;
   assign p2_latch_out               = p2_latch;
   assign p0_out                     = p0_ff;
   assign p0_oe_out                  = p0_oe_ff;
   assign p2_out                     = p2_ff;
   assign p2_strong_pullup_out       = pull_ff;
   assign ale_out                    = ale_ff;
   assign program_store_strobe_n_out = pss_n_ff;
   assign rd_n_out                   = rd_n_ff;
   assign wr_n_out                   = wr_n_ff;

   // Helper: current cycle carries a 16-bit address on port 2
   assign wide_q = (op_ff == emb_pkg::EMB_FETCH)
                || (op_ff != emb_pkg::EMB_NONE && req_ff.ptr_mode);

   // Checks on the pins this block drives
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   pss_fetch_only_a: assert property (
      !program_store_strobe_n_out |-> op_ff == emb_pkg::EMB_FETCH)
      else $error("program strobe outside a fetch");
   rd_wr_data_a: assert property (
      (!rd_n_out || !wr_n_out) |-> (op_ff == emb_pkg::EMB_READ
         || op_ff == emb_pkg::EMB_WRITE) && (rd_n_out || wr_n_out))
      else $error("data strobe outside a data cycle");
   fetch_full_addr_a: assert property (
      (ale_out && op_ff == emb_pkg::EMB_FETCH)
         |-> {p2_out, p0_out} == req_ff.addr)
      else $error("fetch address not on ports 0 and 2");
   p0_drive_both_a: assert property (
      ale_out |-> p0_oe_out == emb_pkg::EMB_ALL_DRIVE)
      else $error("port 0 not fully driven for address");
   p0_latch_ones_a: assert property (
      (req_valid_in && req_ready_out && req_in.op != emb_pkg::EMB_NONE
         && (req_in.op != emb_pkg::EMB_FETCH || fetch_ext))
      |=> p0_latch_out == emb_pkg::EMB_P0_BUS_LOAD)
      else $error("port 0 latch not loaded with ones");
   p2_addr_hold_a: assert property (
      (op_ff != emb_pkg::EMB_NONE && phase_ff != 3'h0 && wide_q)
         |-> $stable(p2_out) && p2_out == req_ff.addr[15:8])
      else $error("port 2 address moved in cycle");
   p2_latch_kept_a: assert property (
      (wide_q && !p2_latch_wr_in) |=> $stable(p2_latch_out))
      else $error("port 2 latch changed by bus cycle");
   page_select_a: assert property (
      (op_ff != emb_pkg::EMB_NONE && !wide_q)
         |-> p2_out == $past(p2_latch_out)
          && p2_strong_pullup_out == 8'h00)
      else $error("port 2 lost latch in 8-bit transfer");
   pullup_cycle_a: assert property (
      wide_q |-> p2_strong_pullup_out == p2_out)
      else $error("strong pull-up not on address ones");
   read_len_a: assert property (
      (req_valid_in && req_ready_out && req_in.op == emb_pkg::EMB_READ)
      |=> (ale_out && rd_n_out) ##2 !rd_n_out [*3]
          ##1 (rd_n_out && rsp_valid_out) ##1 req_ready_out)
      else $error("read cycle not six periods");
   fetch_len_a: assert property (
      (req_valid_in && req_ready_out && req_in.op == emb_pkg::EMB_FETCH
         && fetch_ext)
      |=> ale_out ##1 !program_store_strobe_n_out [*2]
          ##1 (program_store_strobe_n_out && !rsp_valid_out)
          ##1 (rsp_valid_out && req_ready_out))
      else $error("fetch cycle not three periods");
   internal_fetch_a: assert property (
      (req_valid_in && req_ready_out && req_in.op == emb_pkg::EMB_FETCH
         && !fetch_ext)
      |=> rsp_valid_out && rsp_out.internal && program_store_strobe_n_out
          && !ale_out)
      else $error("internal fetch touched the bus");
   write_data_a: assert property (
      $fell(wr_n_out) |-> $past(p0_oe_out) == emb_pkg::EMB_ALL_DRIVE
         && $stable(p0_out) ##3 (wr_n_out && $stable(p0_out)
         && p0_oe_out == emb_pkg::EMB_ALL_DRIVE))
      else $error("write data not around write strobe");
   ale_low_addr_a: assert property (
      ale_out |-> p0_out == req_ff.addr[7:0])
      else $error("latch strobe without low address");

   fetch_ext_c:  cover property (ale_out && op_ff == emb_pkg::EMB_FETCH);
   read_ptr_c:   cover property (!rd_n_out && wide_q);
   write_reg_c:  cover property (!wr_n_out && !wide_q);
   fetch_int_c:  cover property (rsp_valid_out && rsp_out.internal);

endmodule
`default_nettype wire

//--- verilog/emb_port_latch.sv
// Port latch register with core write and forced load
`timescale 1ns/1ps
`default_nettype none
module emb_port_latch #(
   parameter logic [7:0] RESET_VAL = emb_pkg::EMB_LATCH_RESET,
   parameter logic [7:0] LOAD_VAL  = emb_pkg::EMB_P0_BUS_LOAD
) (
   input  wire logic       clock_in,
   input  wire logic       rst_in,
   input  wire logic       wr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       load_in,
   output logic      [7:0] q_out
);

   logic [7:0] latch_ff;
   logic [7:0] nxt_latch;

   // Forced load beats a core write in the same cycle
   always_comb begin
      nxt_latch = latch_ff;
      if (load_in) begin
         nxt_latch = LOAD_VAL;
      end else if (wr_in) begin
         nxt_latch = wdata_in;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         latch_ff <= RESET_VAL;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   assign q_out = latch_ff;

endmodule
`default_nettype wire

//--- verilog/emb_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module emb_sync #(
   parameter int         W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         clock_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   // First stage feeds only the second
   always_comb begin
      nxt_meta = d_in;
      nxt_q    = meta_ff;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff <= RESET_VAL;
         q_ff    <= RESET_VAL;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q_out = q_ff;

endmodule
`default_nettype wire
